// File: design/buck_ocp_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 125 MHz hclk, 32-bit AHB-Lite register bus.
// Notes:   Definitions only.
`ifndef BUCK_OCP_CONSTS_SVH
`define BUCK_OCP_CONSTS_SVH

`define OCP_CLK_PERIOD_NS   8
`define OCP_SS_TIME_NS      2800000
`define OCP_SS_CLKS \
  ((`OCP_SS_TIME_NS + `OCP_CLK_PERIOD_NS - 1) / `OCP_CLK_PERIOD_NS)
`define OCP_TON_MIN_NS      25
`define OCP_TON_MIN_CLKS \
  ((`OCP_TON_MIN_NS + `OCP_CLK_PERIOD_NS - 1) / `OCP_CLK_PERIOD_NS)
`define OCP_CLAMP_EVENTS    5'h10
`define OCP_HICCUP_TC       10'h200
`define OCP_CLEAN_CYCLES    3'h4
`define OCP_OFF_CYCLES      16384

`define OCP_PERIOD_RESET    16'h0138
`define OCP_PERIOD_MIN      16'h0008

`define OCP_ADDR_PERIOD     8'h00
`define OCP_ADDR_STATUS     8'h04
`define OCP_ADDR_COUNT      8'h08
`define OCP_ADDR_OFFCNT     8'h0C

`define OCP_ST_STATE_LSB    0
`define OCP_ST_CLAMP        4
`define OCP_ST_SKIP         5
`define OCP_ST_VOUT_LSB     6
`define OCP_ST_BIAS8        8
`define OCP_ST_COMP_INT     9
`define OCP_ST_VOUT_VALID   10
`define OCP_ST_COMP_VALID   11
`define OCP_CNT_CLAMP_LSB   16

`endif

// File: design/buck_ocp_pkg.sv
// Purpose: Types shared by the overcurrent and hiccup supervisor.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package buck_ocp_pkg;

  typedef enum logic [3:0] {
    ST_SOFT_START    = 4'h1,
    ST_WAIT_FEEDBACK = 4'h2,
    ST_RUN           = 4'h4,
    ST_OFF           = 4'h8
  } hic_state_e;

  typedef enum logic [1:0] {
    VOUT_3V3 = 2'h0,
    VOUT_5V0 = 2'h1,
    VOUT_12V = 2'h2,
    VOUT_EXT = 2'h3
  } vout_sel_e;

endpackage : buck_ocp_pkg

// File: design/strap_latch.sv
// Purpose: Capture a strap value once and hold it until reset.
// Assumes: Reset is only released when supply power is reapplied.
// Notes:   The first cycle with capture_en high wins.
`timescale 1ns/10ps
module strap_latch #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         capture_en,
  input  wire logic [W-1:0] strap_in,
  output logic      [W-1:0] held,
  output logic              valid
);

  logic [W-1:0] held_r;
  logic [W-1:0] held_nxt;
  logic         valid_r;
  logic         valid_nxt;

  always_comb begin
    held_nxt  = held_r;
    valid_nxt = valid_r;
    if (capture_en && !valid_r) begin
      held_nxt  = strap_in;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_r  <= '0;
      valid_r <= 1'b0;
    end else begin
      held_r  <= held_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign held  = held_r;
  assign valid = valid_r;

endmodule : strap_latch

// File: design/buck_overcurrent_hiccup_control.sv
// Purpose: Current limit, soft-start clamp, hiccup sequencing and straps.
// Assumes: Comparator and strap inputs are synchronous to hclk.
// Notes:
// Notes on behaviour
// - Sensed current above limit ends the high-side pulse at once.
// - Enable the soft-start clamp only after sixteen overcurrent events.
// - After soft-start, count current-limit cycles up to 512.
// - Four clean switching cycles in a row clear the hiccup counter.
// - Terminal count with feedback above 400 mV restarts the counter.
// - Terminal count with feedback low discharges soft-start, stops drivers.
// - Off-time count of 16384 restarts soft-start.
// - Hiccup inactive in soft-start and until feedback first exceeds 0.4 V.
// - Decode output-voltage strap and choose the bias level from it.
// - Output-voltage choice captured once, held until power recycles.
// - Internal compensation only if the 100 kilohm strap is detected.
// - Compensation choice held until power recycles and bias undervoltage.
// - Below minimum on-time the converter skips pulses to keep regulating.
// - Soft-start lasts a fixed 2.8 ms before hiccup arms.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "buck_ocp_consts.svh"
module buck_overcurrent_hiccup_control #(
  parameter int SS_CLKS    = `OCP_SS_CLKS,
  parameter int OFF_CYCLES = `OCP_OFF_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        current_limit_trip,
  input  wire logic        pwm_reset,
  input  wire logic        feedback_above_400mv,
  input  wire logic [1:0]  feedback_strap_code,
  input  wire logic        comp_strap_100k,
  input  wire logic        bias_uvlo,
  output logic             hs_drive,
  output logic             ls_drive,
  output logic             gate_enable,
  output logic             ss_discharge,
  output logic             ss_clamp_enable,
  output logic             pulse_skip,
  output logic [1:0]       vout_select,
  output logic             bias_8v_select,
  output logic             comp_internal
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam logic [18:0] SS_LAST  = 19'(SS_CLKS - 1);
  localparam logic [14:0] OFF_LAST = 15'(OFF_CYCLES - 1);
  localparam logic [3:0]  TON_MIN  = 4'(`OCP_TON_MIN_CLKS);

  buck_ocp_pkg::hic_state_e state_r, state_nxt;
  logic [18:0] ss_cnt_r, ss_cnt_nxt;
  logic [9:0]  hic_cnt_r, hic_cnt_nxt;
  logic [2:0]  clean_r, clean_nxt;
  logic [14:0] off_cnt_r, off_cnt_nxt;
  logic [4:0]  clamp_cnt_r, clamp_cnt_nxt;
  logic        clamp_en_r, clamp_en_nxt;
  logic        discharge_r, discharge_nxt;
  logic        gate_en_r, gate_en_nxt;

  logic [15:0] period_r, period_nxt;
  logic [15:0] phase_r, phase_nxt;
  logic        hs_r, hs_nxt;
  logic        ls_r, ls_nxt;
  logic        oc_seen_r, oc_seen_nxt;
  logic [3:0]  on_cnt_r, on_cnt_nxt;
  logic        skip_pend_r, skip_pend_nxt;
  logic        skip_r, skip_nxt;

  logic        sw_tick;
  logic        oc_event;
  logic        drive_ok;

  logic        ap_write_r, ap_write_nxt;
  logic [7:0]  ap_addr_r, ap_addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        addr_valid;

  logic [2:0]  vout_held;
  logic        vout_valid;
  logic        comp_held;
  logic        comp_valid;
  logic [2:0]  vout_decoded;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up straps.

  // Bias level is 5 V for the two low fixed outputs, 8 V otherwise.
  always_comb begin
    vout_decoded = {1'b1, feedback_strap_code};
    if (feedback_strap_code == buck_ocp_pkg::VOUT_3V3 ||
        feedback_strap_code == buck_ocp_pkg::VOUT_5V0) begin
      vout_decoded = {1'b0, feedback_strap_code};
    end
  end

  strap_latch #(.W(3)) u_vout_strap (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .capture_en (1'b1),
    .strap_in   (vout_decoded),
    .held       (vout_held),
    .valid      (vout_valid)
  );

  // Compensation is judged only once the bias rail is above undervoltage.
  strap_latch #(.W(1)) u_comp_strap (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .capture_en (!bias_uvlo),
    .strap_in   (comp_strap_100k),
    .held       (comp_held),
    .valid      (comp_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Switching-cycle divider and high-side pulse.

  // A period shortened below the running phase ends the cycle at once.
  assign sw_tick  = (phase_r >= period_r - 16'h0001);
  assign drive_ok = (state_r != buck_ocp_pkg::ST_OFF);
  // A trip in the last clock of the cycle still counts for this cycle.
  assign oc_event = oc_seen_r | (hs_r & current_limit_trip);

  always_comb begin
    phase_nxt     = sw_tick ? 16'h0000 : phase_r + 16'h0001;
    hs_nxt        = hs_r;
    oc_seen_nxt   = oc_seen_r | (hs_r & current_limit_trip);
    on_cnt_nxt    = hs_r ? on_cnt_r + {3'h0, on_cnt_r != 4'hF} : on_cnt_r;
    skip_pend_nxt = skip_pend_r;
    skip_nxt      = skip_r;
    // No add on the count, so a saturated on-time cannot wrap to short.
    if (hs_r && pwm_reset && (on_cnt_r < TON_MIN - 4'h1)) begin
      skip_pend_nxt = 1'b1;
    end
    if (hs_r && (current_limit_trip || pwm_reset)) begin
      hs_nxt = 1'b0;
    end
    if (sw_tick) begin
      oc_seen_nxt   = 1'b0;
      on_cnt_nxt    = 4'h0;
      skip_nxt      = skip_pend_nxt;
      skip_pend_nxt = 1'b0;
      hs_nxt        = drive_ok && !skip_nxt;
    end
    if (!drive_ok || state_nxt == buck_ocp_pkg::ST_OFF) begin
      hs_nxt = 1'b0;
    end
    ls_nxt = gate_en_nxt && !hs_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r     <= 16'h0000;
      hs_r        <= 1'b0;
      ls_r        <= 1'b0;
      oc_seen_r   <= 1'b0;
      on_cnt_r    <= 4'h0;
      skip_pend_r <= 1'b0;
      skip_r      <= 1'b0;
    end else begin
      phase_r     <= phase_nxt;
      hs_r        <= hs_nxt;
      ls_r        <= ls_nxt;
      oc_seen_r   <= oc_seen_nxt;
      on_cnt_r    <= on_cnt_nxt;
      skip_pend_r <= skip_pend_nxt;
      skip_r      <= skip_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start, clamp and hiccup sequencer.

  always_comb begin
    state_nxt     = state_r;
    ss_cnt_nxt    = ss_cnt_r;
    hic_cnt_nxt   = hic_cnt_r;
    clean_nxt     = clean_r;
    off_cnt_nxt   = off_cnt_r;
    clamp_cnt_nxt = clamp_cnt_r;
    if (sw_tick && oc_event && drive_ok &&
        clamp_cnt_r != `OCP_CLAMP_EVENTS) begin
      clamp_cnt_nxt = clamp_cnt_r + 5'h01;
    end
    case (state_r)
      buck_ocp_pkg::ST_SOFT_START: begin
        ss_cnt_nxt = ss_cnt_r + 19'h00001;
        if (ss_cnt_r == SS_LAST) begin
          state_nxt = buck_ocp_pkg::ST_WAIT_FEEDBACK;
        end
      end
      buck_ocp_pkg::ST_WAIT_FEEDBACK: begin
        hic_cnt_nxt = 10'h000;
        clean_nxt   = 3'h0;
        if (feedback_above_400mv) begin
          state_nxt = buck_ocp_pkg::ST_RUN;
        end
      end
      buck_ocp_pkg::ST_RUN: begin
        if (sw_tick && oc_event) begin
          clean_nxt = 3'h0;
          if (hic_cnt_r == `OCP_HICCUP_TC - 10'h001) begin
            hic_cnt_nxt = 10'h000;
            if (!feedback_above_400mv) begin
              state_nxt   = buck_ocp_pkg::ST_OFF;
              off_cnt_nxt = 15'h0000;
            end
          end else begin
            hic_cnt_nxt = hic_cnt_r + 10'h001;
          end
        end else if (sw_tick) begin
          clean_nxt = clean_r + 3'h1;
          if (clean_r == `OCP_CLEAN_CYCLES - 3'h1) begin
            hic_cnt_nxt = 10'h000;
            clean_nxt   = 3'h0;
          end
        end
      end
      buck_ocp_pkg::ST_OFF: begin
        if (sw_tick) begin
          off_cnt_nxt = off_cnt_r + 15'h0001;
          if (off_cnt_r == OFF_LAST) begin
            state_nxt     = buck_ocp_pkg::ST_SOFT_START;
            ss_cnt_nxt    = 19'h00000;
            clamp_cnt_nxt = 5'h00;
          end
        end
      end
      default: begin
        state_nxt = buck_ocp_pkg::ST_SOFT_START;
      end
    endcase
    clamp_en_nxt  = (clamp_cnt_nxt == `OCP_CLAMP_EVENTS);
    discharge_nxt = (state_nxt == buck_ocp_pkg::ST_OFF);
    gate_en_nxt   = (state_nxt != buck_ocp_pkg::ST_OFF);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= buck_ocp_pkg::ST_SOFT_START;
      ss_cnt_r    <= 19'h00000;
      hic_cnt_r   <= 10'h000;
      clean_r     <= 3'h0;
      off_cnt_r   <= 15'h0000;
      clamp_cnt_r <= 5'h00;
      clamp_en_r  <= 1'b0;
      discharge_r <= 1'b0;
      gate_en_r   <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      ss_cnt_r    <= ss_cnt_nxt;
      hic_cnt_r   <= hic_cnt_nxt;
      clean_r     <= clean_nxt;
      off_cnt_r   <= off_cnt_nxt;
      clamp_cnt_r <= clamp_cnt_nxt;
      clamp_en_r  <= clamp_en_nxt;
      discharge_r <= discharge_nxt;
      gate_en_r   <= gate_en_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, read data prepared in address phase.

  assign addr_valid = hsel && hready && htrans[1];

  always_comb begin
    ap_write_nxt = addr_valid && hwrite;
    ap_addr_nxt  = addr_valid ? haddr[7:0] : ap_addr_r;
    period_nxt   = period_r;
    rdata_nxt    = 32'h00000000;
    if (ap_write_r && ap_addr_r == `OCP_ADDR_PERIOD) begin
      period_nxt = (hwdata[15:0] < `OCP_PERIOD_MIN) ?
                   `OCP_PERIOD_MIN : hwdata[15:0];
    end
    if (addr_valid && !hwrite) begin
      case (haddr[7:0])
        `OCP_ADDR_PERIOD: rdata_nxt[15:0] = period_nxt;
        `OCP_ADDR_STATUS: begin
          rdata_nxt[`OCP_ST_STATE_LSB +: 4] = state_r;
          rdata_nxt[`OCP_ST_CLAMP]          = clamp_en_r;
          rdata_nxt[`OCP_ST_SKIP]           = skip_r;
          rdata_nxt[`OCP_ST_VOUT_LSB +: 2]  = vout_held[1:0];
          rdata_nxt[`OCP_ST_BIAS8]          = vout_held[2];
          rdata_nxt[`OCP_ST_COMP_INT]       = comp_held;
          rdata_nxt[`OCP_ST_VOUT_VALID]     = vout_valid;
          rdata_nxt[`OCP_ST_COMP_VALID]     = comp_valid;
        end
        `OCP_ADDR_COUNT: begin
          rdata_nxt[9:0]                    = hic_cnt_r;
          rdata_nxt[`OCP_CNT_CLAMP_LSB +: 5] = clamp_cnt_r;
        end
        `OCP_ADDR_OFFCNT: rdata_nxt[14:0] = off_cnt_r;
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write_r <= 1'b0;
      ap_addr_r  <= 8'h00;
      period_r   <= `OCP_PERIOD_RESET;
      rdata_r    <= 32'h00000000;
    end else begin
      ap_write_r <= ap_write_nxt;
      ap_addr_r  <= ap_addr_nxt;
      period_r   <= period_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = rdata_r;
  assign hs_drive        = hs_r;
  assign ls_drive        = ls_r;
  assign gate_enable     = gate_en_r;
  assign ss_discharge    = discharge_r;
  assign ss_clamp_enable = clamp_en_r;
  assign pulse_skip      = skip_r;
  assign vout_select     = vout_held[1:0];
  assign bias_8v_select  = vout_held[2];
  assign comp_internal   = comp_held;

endmodule : buck_overcurrent_hiccup_control

// File: verif/power_stage_model.sv
// Purpose: Behavioural power stage with current and PWM comparators.
// Assumes: Comparator outputs are synchronous to hclk.
// Notes:   Overload makes every pulse hit the current limit.
`timescale 1ns/10ps
module power_stage_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       overload,
  input  wire logic       feedback_good,
  input  wire logic [3:0] on_clks,
  input  wire logic       hs_drive,
  output logic            current_limit_trip,
  output logic            pwm_reset,
  output logic            feedback_above_400mv
);
  logic [7:0] on_cnt_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cnt_r <= 8'h00;
    end else begin
      on_cnt_r <= hs_drive ? on_cnt_r + 8'h01 : 8'h00;
    end
  end

  // Current only rises while the high side conducts.
  assign current_limit_trip = overload && hs_drive &&
                              on_cnt_r >= 8'h02;
  assign pwm_reset = !overload && hs_drive && on_cnt_r >= {4'h0, on_clks};
  assign feedback_above_400mv = feedback_good;
endmodule : power_stage_model

// File: verif/buck_ocp_assertions.sv
// Purpose: Port-level checks of the overcurrent and hiccup supervisor.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to the design top below.
`timescale 1ns/10ps
module buck_ocp_assertions #(
  parameter int SS_CLKS    = 50,
  parameter int OFF_CYCLES = 8
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       current_limit_trip,
  input wire logic       feedback_above_400mv,
  input wire logic       comp_strap_100k,
  input wire logic       bias_uvlo,
  input wire logic       hs_drive,
  input wire logic       ls_drive,
  input wire logic       gate_enable,
  input wire logic       ss_discharge,
  input wire logic       ss_clamp_enable,
  input wire logic       pulse_skip,
  input wire logic [1:0] vout_select,
  input wire logic       bias_8v_select,
  input wire logic       comp_internal
);
  logic started_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  trip_ends_hs_a: assert property (
    hs_drive && current_limit_trip |=> !hs_drive)
    else $error("high side not ended after trip");
  off_gates_a: assert property (
    ss_discharge |-> !gate_enable && !hs_drive && !ls_drive)
    else $error("drivers active during off time");
  off_entry_a: assert property (
    $rose(ss_discharge) |-> !$past(feedback_above_400mv))
    else $error("off time entered with feedback high");
  off_exit_a: assert property ($fell(ss_discharge) |-> gate_enable)
    else $error("drivers not re-enabled after off time");
  clamp_clear_a: assert property (
    $fell(ss_clamp_enable) |->
      $past(ss_discharge) || $past(ss_discharge, 2))
    else $error("clamp cleared outside restart");
  vout_hold_a: assert property (started_r |=> $stable(vout_select))
    else $error("output voltage choice changed");
  bias_map_a: assert property (
    started_r |-> bias_8v_select == vout_select[1])
    else $error("bias level does not follow output choice");
  comp_rise_a: assert property (
    $rose(comp_internal) |->
      $past(comp_strap_100k) && !$past(bias_uvlo))
    else $error("internal compensation without strap");
  comp_hold_a: assert property (!$fell(comp_internal))
    else $error("compensation choice dropped");
  skip_no_hs_a: assert property (pulse_skip |-> !hs_drive)
    else $error("pulse issued in skipped cycle");

  cover property (hs_drive && current_limit_trip);
  cover property ($rose(ss_discharge));
  cover property ($rose(ss_clamp_enable));
  cover property ($rose(pulse_skip));
endmodule : buck_ocp_assertions

bind buck_overcurrent_hiccup_control buck_ocp_assertions #(
  .SS_CLKS(SS_CLKS), .OFF_CYCLES(OFF_CYCLES)
) u_chk (
  .hclk(hclk), .hresetn(hresetn), .current_limit_trip(current_limit_trip),
  .feedback_above_400mv(feedback_above_400mv),
  .comp_strap_100k(comp_strap_100k),
  .bias_uvlo(bias_uvlo), .hs_drive(hs_drive), .ls_drive(ls_drive),
  .gate_enable(gate_enable), .ss_discharge(ss_discharge),
  .ss_clamp_enable(ss_clamp_enable), .pulse_skip(pulse_skip),
  .vout_select(vout_select), .bias_8v_select(bias_8v_select),
  .comp_internal(comp_internal)
);

// File: verif/tb_top.sv
// Purpose: Scenario testbench for the overcurrent and hiccup supervisor.
// Assumes: Zero-wait-state register bus, period set to 16 clocks.
// Notes:   Soft-start and off-time counts are shortened by parameter.
`timescale 1ns/10ps
module tb_top;
  localparam int SS = 50;
  localparam int OFFC = 8;
  localparam int PER = 16;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, a;
  logic [1:0]  htrans, strap, vout_select;
  logic [2:0]  hsize;
  logic [3:0]  on_clks;
  logic        trip, pwm_rst, feedback_ok, comp_strap, uvlo, overload;
  logic        feedback_good;
  logic        hs, ls, gate_en, ss_dis, clamp, skip, bias8, comp_int;
  int          errors, n_compared, n;

  buck_overcurrent_hiccup_control #(.SS_CLKS(SS), .OFF_CYCLES(OFFC)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .current_limit_trip(trip), .pwm_reset(pwm_rst),
    .feedback_above_400mv(feedback_ok), .feedback_strap_code(strap),
    .comp_strap_100k(comp_strap), .bias_uvlo(uvlo), .hs_drive(hs),
    .ls_drive(ls), .gate_enable(gate_en), .ss_discharge(ss_dis),
    .ss_clamp_enable(clamp), .pulse_skip(skip), .vout_select(vout_select),
    .bias_8v_select(bias8), .comp_internal(comp_int));

  power_stage_model u_stage (
    .hclk(hclk), .hresetn(hresetn), .overload(overload),
    .feedback_good(feedback_good), .on_clks(on_clks), .hs_drive(hs),
    .current_limit_trip(trip), .pwm_reset(pwm_rst),
    .feedback_above_400mv(feedback_ok));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h000000, ad}; htrans <= 2'h2; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic do_reset(input logic [1:0] c, input logic cs, input logic uv);
    @(posedge hclk);
    hresetn <= 1'b0; strap <= c; comp_strap <= cs; uvlo <= uv;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_straps();
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i), i[0], 1'b0);
      chk(32'(vout_select), i);
      chk(32'(bias8), 32'(i >= 2));
      chk(32'(comp_int), 32'(i[0]));
    end
    strap <= 2'h0; comp_strap <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(32'(vout_select), 32'h3);
    chk(32'(comp_int), 32'h1);
    do_reset(2'h1, 1'b1, 1'b1);
    chk(32'(comp_int), 32'h0);
    uvlo <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(32'(comp_int), 32'h1);
  endtask : t_straps

  task automatic t_regs_softstart();
    do_reset(2'h1, 1'b1, 1'b0);
    overload <= 1'b1; feedback_good <= 1'b0;
    bus(1'b0, 8'h00, 32'h0); chk(q, 32'h00000138);
    chk(32'(hresp), 32'h0);
    bus(1'b1, 8'h00, 32'h3); bus(1'b0, 8'h00, 32'h0); chk(q, 32'h8);
    bus(1'b1, 8'h00, PER); bus(1'b0, 8'h10, 32'h0); chk(q, 32'h0);
    bus(1'b1, 8'h04, 32'hFFFF); bus(1'b0, 8'h04, 32'h0);
    chk({28'h0, q[3:0]}, 32'h1);
    repeat (SS + 20) @(posedge hclk);
    bus(1'b0, 8'h04, 32'h0); chk({28'h0, q[3:0]}, 32'h2);
    bus(1'b0, 8'h08, 32'h0); chk({22'h0, q[9:0]}, 32'h0);
    chk(32'(clamp), 32'h0);
    repeat (14 * PER) @(posedge hclk);
    chk(32'(clamp), 32'h1);
    bus(1'b0, 8'h08, 32'h0); chk({27'h0, q[20:16]}, 32'h10);
  endtask : t_regs_softstart

  task automatic t_run_count();
    feedback_good <= 1'b1;
    repeat (10 * PER) @(posedge hclk);
    bus(1'b0, 8'h04, 32'h0); chk({28'h0, q[3:0]}, 32'h4);
    bus(1'b0, 8'h08, 32'h0); a = q;
    chk(32'(a[9:0] != 10'h000), 32'h1);
    overload <= 1'b0;
    repeat (2 * PER) @(posedge hclk);
    overload <= 1'b1;
    repeat (2 * PER) @(posedge hclk);
    bus(1'b0, 8'h08, 32'h0); chk(32'(q[9:0] > a[9:0]), 32'h1);
    overload <= 1'b0;
    repeat (6 * PER) @(posedge hclk);
    bus(1'b0, 8'h08, 32'h0); chk({22'h0, q[9:0]}, 32'h0);
    overload <= 1'b1;
    repeat (520 * PER) @(posedge hclk);
    bus(1'b0, 8'h04, 32'h0); chk({28'h0, q[3:0]}, 32'h4);
    bus(1'b0, 8'h08, 32'h0); chk(32'(q[9:0] < 10'h040), 32'h1);
  endtask : t_run_count

  task automatic t_hiccup_off();
    feedback_good <= 1'b0;
    for (n = 0; n < 600 * PER && ss_dis !== 1'b1; n++) @(posedge hclk);
    chk(32'(ss_dis), 32'h1);
    chk(32'(gate_en), 32'h0);
    chk(32'(ls), 32'h0);
    for (n = 0; n < 40 * PER && ss_dis !== 1'b0; n++) @(posedge hclk);
    chk(32'(n >= (OFFC - 1) * PER && n <= (OFFC + 1) * PER), 32'h1);
    bus(1'b0, 8'h04, 32'h0); chk({28'h0, q[3:0]}, 32'h1);
  endtask : t_hiccup_off

  task automatic t_skip();
    overload <= 1'b0; feedback_good <= 1'b1; on_clks <= 4'h1;
    for (n = 0; n < 40 * PER && skip !== 1'b1; n++) @(posedge hclk);
    chk(32'(skip), 32'h1);
    chk(32'(hs), 32'h0);
  endtask : t_skip

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    repeat (40000) @(posedge hclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0; n_compared = 0; hresetn = 1'b0; hsel = 1'b0;
    haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; strap = 2'h0; comp_strap = 1'b0; uvlo = 1'b0;
    overload = 1'b0; feedback_good = 1'b0; on_clks = 4'h6;
    t_straps();
    t_regs_softstart();
    t_run_count();
    t_hiccup_off();
    t_skip();
    tally_and_finish();
  end
endmodule : tb_top
